// file: logic/stsr_responder.sv
`timescale 1ns/1ps
module stsr_responder
    import stsr_pkg::*;
#(
    parameter int CHIPS    = 4,
    parameter int SPARE_W  = 16,
    parameter int ERASE_W  = 32
)(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    // Task file command strobe and registers
    input  wire logic                       cmd_wr,
    input  wire logic [7:0]                 cmd_code,
    input  wire logic [7:0]                 features,
    input  wire logic [7:0]                 cyl_lo_in,
    input  wire logic [7:0]                 cyl_hi_in,
    input  wire logic [7:0]                 drv_head,
    input  wire logic                       drv_sel,
    // Configuration and wear inputs
    input  wire logic [7:0]                 spare_thr,
    input  wire logic [7:0]                 erase_thr,
    input  wire logic [CHIPS*SPARE_W-1:0]   spare_init,
    input  wire logic [CHIPS*SPARE_W-1:0]   spare_cur,
    input  wire logic [ERASE_W-1:0]         erase_done,
    input  wire logic [ERASE_W-1:0]         erase_target,
    // Flash read events
    input  wire logic                       flash_read,
    input  wire logic                       udma_crc_err,
    // Sector data stream to the host
    output logic                            data_valid,
    input  wire logic                       data_ready,
    output logic [7:0]                      data_byte,
    output logic                            data_last,
    // Command completion and cylinder results
    output logic                            cmd_done,
    output logic [7:0]                      cyl_lo_out,
    output logic [7:0]                      cyl_hi_out,
    output logic                            cmd_abort,
    // Attribute views
    output logic [7:0]                      spare_value,
    output logic [7:0]                      erase_value,
    output logic [47:0]                     read_count,
    output logic [31:0]                     crc_count,
    output logic [95:0]                     reads_attr,
    output logic [95:0]                     crc_attr
);

    typedef enum logic [1:0] {
        STSR_IDLE = 2'b00,
        STSR_SEND = 2'b01,
        STSR_DONE = 2'b10
    } stsr_state_t;

    stsr_state_t state;
    stsr_state_t next_state;
    logic [8:0]  byte_idx;
    logic [7:0]  sum;

    // Threshold byte generator for one sector offset
    function automatic logic [7:0] thr_byte(input logic [8:0] ofs,
                                            input logic [7:0] s_thr,
                                            input logic [7:0] e_thr);
        logic [8:0] rel;
        logic [3:0] ent;
        logic [3:0] pos;
        rel = 9'h000;
        ent = 4'h0;
        pos = 4'h0;
        thr_byte = 8'h00;
        if (ofs == 9'h000)
            thr_byte = STRUCT_VERSION[7:0];
        else if (ofs == 9'h001)
            thr_byte = STRUCT_VERSION[15:8];
        else if (ofs < 9'(ENTRY_BASE + ENTRY_USED * ENTRY_BYTES))
        begin
            rel = ofs - 9'(ENTRY_BASE);
            ent = 4'(rel / 9'(ENTRY_BYTES));
            pos = 4'(rel % 9'(ENTRY_BYTES));
            if (pos == 4'h0)
            begin
                unique case (ent)
                    4'h0:    thr_byte = ID_SPARE;
                    4'h1:    thr_byte = ID_ERASE;
                    4'h2:    thr_byte = ID_ECC_TOT;
                    4'h3:    thr_byte = ID_ECC_COR;
                    4'h4:    thr_byte = ID_READS;
                    default: thr_byte = ID_CRC;
                endcase
            end
            else if (pos == 4'h1 && ent == 4'h0)
                thr_byte = s_thr;
            else if (pos == 4'h1 && ent == 4'h1)
                thr_byte = e_thr;
        end
        // Unused entry slots and tail stay zero
    endfunction : thr_byte

    // Command decode; bits 7:5 of drive/head must be set and drive must match
    wire drv_ok   = cmd_wr && cmd_code == CMD_SMART
                    && drv_head[7:5] == DRVHEAD_FIXED
                    && drv_head[DRVHEAD_DRV_BIT] == drv_sel;
    wire addr_ok  = drv_ok && cyl_lo_in == CYL_LO_KEY && cyl_hi_in == CYL_HI_KEY;
    wire go_thr   = addr_ok && features == FEAT_READ_THR && state == STSR_IDLE;
    wire go_stat  = addr_ok && features == FEAT_RET_STATUS && state == STSR_IDLE;
    // A command for the other drive is left alone; only our own bad ones abort
    wire go_bad   = drv_ok && state == STSR_IDLE
                    && !go_thr && !go_stat;

    // Per-chip spare percentage and minimum over all chips
    logic [7:0] chip_pct [CHIPS];
    genvar gi;
    generate
        for (gi = 0; gi < CHIPS; gi++)
        begin : g_chip
            wire [SPARE_W+6:0] scaled = (SPARE_W+7)'(spare_cur[gi*SPARE_W +: SPARE_W])
                                        * (SPARE_W+7)'(PERCENT_FULL);
            wire [SPARE_W-1:0] init   = spare_init[gi*SPARE_W +: SPARE_W];
            wire [SPARE_W+6:0] quo    = (init == '0) ? '0 : scaled / (SPARE_W+7)'(init);
            assign chip_pct[gi] = (quo > (SPARE_W+7)'(PERCENT_FULL)) ? 8'(PERCENT_FULL)
                                  : quo[7:0];
        end
    endgenerate

    logic [7:0] min_pct;
    always_comb
    begin
        min_pct = 8'(PERCENT_FULL);
        for (int i = 0; i < CHIPS; i++)
            if (chip_pct[i] < min_pct)
                min_pct = chip_pct[i];
    end

    // Remaining life; saturates at zero once the target is used up
    wire [ERASE_W+6:0] used_pct = (erase_target == '0) ? (ERASE_W+7)'(PERCENT_FULL)
        : ((ERASE_W+7)'(erase_done) * (ERASE_W+7)'(PERCENT_FULL))
          / (ERASE_W+7)'(erase_target);
    wire [7:0] life_pct = (used_pct >= (ERASE_W+7)'(PERCENT_FULL)) ? 8'h00
                          : 8'(PERCENT_FULL) - used_pct[7:0];

    // Only spare and erase take part; reads and CRC are not looked at
    // Registered values are compared, so a wear change counts one cycle late
    wire exceeded = (spare_value < spare_thr)
                    || (erase_value < erase_thr);

    // Bytes are built on the fly, so the sector needs no buffer
    wire [7:0] cur_byte = thr_byte(byte_idx, spare_thr, erase_thr);
    wire       at_last  = byte_idx == 9'(CHECKSUM_OFS);
    wire       beat     = data_valid && data_ready;

    assign data_valid = state == STSR_SEND;
    assign data_last  = data_valid && at_last;

    always_comb
    begin
        next_state = state;
        unique case (state)
            STSR_IDLE: if (go_thr) next_state = STSR_SEND;
            STSR_SEND: if (beat && at_last) next_state = STSR_DONE;
            STSR_DONE: next_state = STSR_IDLE;
            default:   next_state = STSR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state    <= STSR_IDLE;
            byte_idx <= 9'h000;
            sum      <= 8'h00;
        end
        else
        begin
            state <= next_state;
            if (go_thr)
            begin
                byte_idx <= 9'h000;
                sum      <= 8'h00;
            end
            else if (beat)
            begin
                byte_idx <= byte_idx + 9'h001;
                sum      <= sum + cur_byte;
            end
        end
    end

    // Checksum replaces the final byte of the sector
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            data_byte <= 8'h00;
        else if (go_thr)
            data_byte <= thr_byte(9'h000, spare_thr, erase_thr);
        else if (beat)
            data_byte <= (byte_idx + 9'h001 == 9'(CHECKSUM_OFS))
                         ? 8'h00 - (sum + cur_byte)
                         : thr_byte(byte_idx + 9'h001, spare_thr, erase_thr);
    end

    // Completion and cylinder result
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_done   <= 1'b0;
            cmd_abort  <= 1'b0;
            cyl_lo_out <= CYL_LO_KEY;
            cyl_hi_out <= CYL_HI_KEY;
        end
        else
        begin
            cmd_done  <= go_stat || go_bad || state == STSR_DONE;
            cmd_abort <= go_bad;
            if (go_stat)
            begin
                cyl_lo_out <= exceeded ? CYL_LO_EXCEED : CYL_LO_KEY;
                cyl_hi_out <= exceeded ? CYL_HI_EXCEED : CYL_HI_KEY;
            end
        end
    end

    // Attribute values and event counters; counters saturate rather than wrap
    // A wrapped counter would read back like a fresh card, hence saturation
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            spare_value <= 8'h64;
            erase_value <= 8'h64;
            read_count  <= 48'h0;
            crc_count   <= 32'h0;
        end
        else
        begin
            spare_value <= min_pct;
            erase_value <= life_pct;
            if (flash_read && read_count != '1)
                read_count <= read_count + 48'h1;
            if (flash_read && udma_crc_err && crc_count != '1)
                crc_count <= crc_count + 32'h1;
        end
    end

    // Byte 0 in the low lane of each entry
    assign reads_attr = {8'h00, read_count, ATTR_FIXED_VAL, ATTR_FIXED_VAL,
                         ATTR_FLAGS_ADV, ID_READS};
    assign crc_attr   = {24'h0, crc_count, ATTR_FIXED_VAL, ATTR_FIXED_VAL,
                         ATTR_FLAGS_ADV, ID_CRC};

endmodule : stsr_responder

// file: include/stsr_pkg.sv
package stsr_pkg;
    // Task file command and subcommand codes
    localparam logic [7:0] CMD_SMART       = 8'hB0;
    localparam logic [7:0] FEAT_READ_THR   = 8'hD1;
    localparam logic [7:0] FEAT_RET_STATUS = 8'hDA;
    localparam logic [7:0] CYL_LO_KEY      = 8'h4F;
    localparam logic [7:0] CYL_HI_KEY      = 8'hC2;
    localparam logic [7:0] CYL_LO_EXCEED   = 8'hF4;
    localparam logic [7:0] CYL_HI_EXCEED   = 8'h2C;
    localparam logic [2:0] DRVHEAD_FIXED   = 3'h7;
    localparam int         DRVHEAD_DRV_BIT = 4;
    // Threshold sector layout
    localparam logic [15:0] STRUCT_VERSION = 16'h0004;
    localparam int          SECTOR_BYTES   = 512;
    localparam int          ENTRY_BYTES    = 12;
    localparam int          ENTRY_BASE     = 2;
    localparam int          ENTRY_USED     = 6;
    localparam int          CHECKSUM_OFS   = 511;
    // Attribute identifiers
    localparam logic [7:0] ID_SPARE   = 8'hC4;
    localparam logic [7:0] ID_ERASE   = 8'hE5;
    localparam logic [7:0] ID_ECC_TOT = 8'hCB;
    localparam logic [7:0] ID_ECC_COR = 8'hCC;
    localparam logic [7:0] ID_READS   = 8'hE8;
    localparam logic [7:0] ID_CRC     = 8'hC7;
    // Attribute entry fixed fields
    localparam logic [15:0] ATTR_FLAGS_ADV = 16'h0002;
    localparam logic [7:0]  ATTR_FIXED_VAL = 8'h64;
    localparam int          PERCENT_FULL   = 100;
endpackage : stsr_pkg

// file: testbench/stsr_responder_asserts.sv
`timescale 1ns/1ps
module stsr_responder_asserts
    import stsr_pkg::*;
(
    // Clock, reset and task file
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        cmd_wr,
    input wire logic [7:0]  cmd_code,
    input wire logic [7:0]  features,
    input wire logic [7:0]  cyl_lo_in,
    input wire logic [7:0]  cyl_hi_in,
    input wire logic [7:0]  drv_head,
    input wire logic        drv_sel,
    // Thresholds and events
    input wire logic [7:0]  spare_thr,
    input wire logic [7:0]  erase_thr,
    input wire logic        flash_read,
    // Stream and results
    input wire logic        data_valid,
    input wire logic        data_ready,
    input wire logic [7:0]  data_byte,
    input wire logic        data_last,
    input wire logic        cmd_done,
    input wire logic [7:0]  cyl_lo_out,
    input wire logic [7:0]  cyl_hi_out,
    input wire logic        cmd_abort,
    input wire logic [7:0]  spare_value,
    input wire logic [7:0]  erase_value,
    input wire logic [95:0] reads_attr,
    input wire logic [95:0] crc_attr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire take = cmd_wr && cmd_code == CMD_SMART && drv_head[7:5] == DRVHEAD_FIXED
        && drv_head[DRVHEAD_DRV_BIT] == drv_sel && !data_valid;
    wire keys = cyl_lo_in == CYL_LO_KEY && cyl_hi_in == CYL_HI_KEY;
    wire exceed = spare_value < spare_thr || erase_value < erase_thr;
    wire [47:0] rc = reads_attr[87:40];
    sequence s_tail;
        !data_valid ##1 cmd_done && !cmd_abort;
    endsequence
    a_read_starts:
        assert property (take && keys && features == FEAT_READ_THR |=> data_valid)
        else $error("threshold read did not start");
    a_version_low:
        assert property ($rose(data_valid) |-> data_byte == STRUCT_VERSION[7:0])
        else $error("first byte is not the version");
    a_last_done:
        assert property (data_valid && data_ready && data_last |=> s_tail)
        else $error("no completion after last byte");
    a_byte_hold:
        assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
        else $error("byte changed while stalled");
    a_status_cyl:
        assert property (take && keys && features == FEAT_RET_STATUS |=> cmd_done
            && cyl_lo_out == ($past(exceed) ? CYL_LO_EXCEED : CYL_LO_KEY)
            && cyl_hi_out == ($past(exceed) ? CYL_HI_EXCEED : CYL_HI_KEY))
        else $error("status cylinder result wrong");
    a_cyl_steady:
        assert property ($changed(cyl_lo_out) || $changed(cyl_hi_out) |-> cmd_done)
        else $error("cylinder output moved without completion");
    a_bad_key:
        assert property (take && !keys |=> cmd_done && cmd_abort)
        else $error("wrong keys not aborted");
    a_reads_count:
        assert property (flash_read && rc != '1 |=> rc == $past(rc) + 48'h1)
        else $error("read count did not advance");
    a_attr_fixed:
        assert property (reads_attr[39:0] == {16'h6464, ATTR_FLAGS_ADV, ID_READS}
            && reads_attr[95:88] == 8'h00 && crc_attr[7:0] == ID_CRC
            && crc_attr[39:24] == 16'h6464 && crc_attr[95:72] == 24'h0)
        else $error("attribute fixed fields wrong");
endmodule : stsr_responder_asserts

// file: testbench/stsr_host_model.sv
`timescale 1ns/1ps
module stsr_host_model
    import stsr_pkg::*;
(
    // Clock and task file
    input  wire logic       mclk,
    output logic            cmd_wr = 1'b0,
    output logic [7:0]      cmd_code = 8'h00,
    output logic [7:0]      features = 8'h00,
    output logic [7:0]      cyl_lo_in = 8'h00,
    output logic [7:0]      cyl_hi_in = 8'h00,
    output logic [7:0]      drv_head = 8'h00,
    output logic            drv_sel = 1'b0,
    // Sector stream
    input  wire logic       data_valid,
    input  wire logic [7:0] data_byte,
    input  wire logic       data_last,
    output logic            data_ready = 1'b0
);
    logic [7:0] rx[$];
    int         last_at = -1;
    // Sampled mid-cycle so the beat decision never races the design's edge
    always @(negedge mclk)
        if (data_valid && data_ready)
        begin
            if (data_last)
                last_at = rx.size();
            rx.push_back(data_byte);
        end
    always @(posedge mclk)
        #1 data_ready = ($urandom_range(0, 3) != 0);
    task automatic issue(input logic [7:0] feat, input logic [7:0] lo);
        @(posedge mclk);
        #1;
        cmd_code = CMD_SMART;
        features = feat;
        cyl_lo_in = lo;
        cyl_hi_in = CYL_HI_KEY;
        drv_sel = 1'($urandom_range(0, 1));
        drv_head = {DRVHEAD_FIXED, drv_sel, 4'h0};
        cmd_wr = 1'b1;
        @(posedge mclk);
        #1;
        cmd_wr = 1'b0;
    endtask : issue
endmodule : stsr_host_model

// file: testbench/smart_threshold_status_responder_tb.sv
`timescale 1ns/1ps
module smart_threshold_status_responder_tb
    import stsr_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, flash_read = 1'b0, udma_crc_err = 1'b0;
    logic cmd_wr, drv_sel, data_ready, data_valid, data_last, cmd_done, cmd_abort, ab;
    logic [7:0] cmd_code, features, cyl_lo_in, cyl_hi_in, drv_head, data_byte;
    logic [7:0] spare_thr = 8'h00, erase_thr = 8'h00;
    logic [7:0] cyl_lo_out, cyl_hi_out, spare_value, erase_value;
    logic [63:0] spare_init = 64'h1, spare_cur = 64'h1;
    logic [31:0] erase_done = 32'h0, erase_target = 32'h1, crc_count;
    logic [47:0] read_count;
    logic [95:0] reads_attr, crc_attr;
    int n_errors = 0, samples_checked = 0, sv, ev, n_rd = 0, n_crc = 0;
    always #20 mclk = ~mclk;
    stsr_responder dut (.mclk, .rst_b, .cmd_wr, .cmd_code, .features, .cyl_lo_in, .cyl_hi_in,
        .drv_head, .drv_sel, .spare_thr, .erase_thr, .spare_init, .spare_cur, .erase_done,
        .erase_target, .flash_read, .udma_crc_err, .data_valid, .data_ready, .data_byte,
        .data_last, .cmd_done, .cyl_lo_out, .cyl_hi_out, .cmd_abort, .spare_value,
        .erase_value, .read_count, .crc_count, .reads_attr, .crc_attr);
    stsr_host_model u_host (.mclk, .cmd_wr, .cmd_code, .features, .cyl_lo_in, .cyl_hi_in,
        .drv_head, .drv_sel, .data_valid, .data_byte, .data_last, .data_ready);
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic wait_done();
        int k = 0;
        while (cmd_done !== 1'b1 && k < 3000)
        begin
            @(negedge mclk);
            k++;
        end
        ab = cmd_abort;
        chk(k < 3000, 1'b1);
        @(posedge mclk);
        #1;
    endtask : wait_done
    task automatic setwear();
        int ini, cur, t, d;
        sv = 100;
        for (int i = 0; i < 4; i++)
        begin
            ini = $urandom_range(1, 1000);
            cur = $urandom_range(0, ini);
            spare_init[i*16+:16] = ini[15:0];
            spare_cur[i*16+:16] = cur[15:0];
            if (cur * 100 / ini < sv) sv = cur * 100 / ini;
        end
        t = $urandom_range(100, 5000);
        d = $urandom_range(0, t + 200);
        erase_target = t;
        erase_done = d;
        ev = (d >= t) ? 0 : 100 - d * 100 / t;
        spare_thr = 8'($urandom_range(0, 100));
        erase_thr = 8'($urandom_range(0, 100));
        repeat (2) @(posedge mclk);
        #1;
        chk(spare_value, sv);
        chk(erase_value, ev);
    endtask : setwear
    task automatic read_thr();
        logic [7:0] ids [6] = '{ID_SPARE, ID_ERASE, ID_ECC_TOT, ID_ECC_COR, ID_READS, ID_CRC};
        int sec[512];
        int sum = 4;
        sec = '{default: 0};
        sec[0] = 4;
        for (int n = 0; n < 6; n++)
            sec[2 + 12 * n] = ids[n];
        sec[3] = spare_thr;
        sec[15] = erase_thr;
        for (int i = 1; i < 511; i++)
            sum += sec[i];
        sec[511] = (256 - sum % 256) % 256;
        u_host.rx.delete();
        u_host.last_at = -1;
        u_host.issue(FEAT_READ_THR, CYL_LO_KEY);
        wait_done();
        chk(u_host.rx.size(), 512);
        chk(u_host.last_at, 511);
        for (int i = 0; i < 512; i++)
            chk(u_host.rx[i], sec[i]);
        $display("threshold read test done");
    endtask : read_thr
    initial
    begin
        void'($urandom(32'hA082));
        repeat (3) @(posedge mclk);
        #1 rst_b = 1'b1;
        chk({cyl_hi_out, cyl_lo_out}, {CYL_HI_KEY, CYL_LO_KEY});
        setwear();
        read_thr();
        repeat (40)
        begin
            @(posedge mclk);
            #1;
            flash_read = 1'($urandom_range(0, 1));
            udma_crc_err = 1'($urandom_range(0, 1));
            n_rd += flash_read;
            n_crc += flash_read & udma_crc_err;
        end
        #40 flash_read = 1'b0;
        @(posedge mclk);
        #1;
        chk(read_count, n_rd);
        chk(crc_attr[71:40], n_crc);
        chk(crc_count, n_crc);
        chk(reads_attr, {8'h00, 48'(n_rd), ATTR_FIXED_VAL, ATTR_FIXED_VAL,
            ATTR_FLAGS_ADV, ID_READS});
        chk(crc_attr, {24'h0, n_crc, ATTR_FIXED_VAL, ATTR_FIXED_VAL,
            ATTR_FLAGS_ADV, ID_CRC});
        $display("read counter test done");
        repeat (10)
        begin
            setwear();
            u_host.issue(FEAT_RET_STATUS, CYL_LO_KEY);
            wait_done();
            if (sv < spare_thr || ev < erase_thr)
                chk({ab, cyl_hi_out, cyl_lo_out}, {1'b0, CYL_HI_EXCEED, CYL_LO_EXCEED});
            else
                chk({ab, cyl_hi_out, cyl_lo_out}, {1'b0, CYL_HI_KEY, CYL_LO_KEY});
        end
        $display("return status test done");
        read_thr();
        u_host.issue(FEAT_READ_THR, 8'h00);
        wait_done();
        chk(ab, 1'b1);
        $display("bad key test done");
        results();
    end
    initial
    begin
        #400000;
        n_errors++;
        results();
    end
endmodule : smart_threshold_status_responder_tb
bind stsr_responder stsr_responder_asserts u_chk (.mclk, .rst_b, .cmd_wr, .cmd_code, .features,
    .cyl_lo_in, .cyl_hi_in, .drv_head, .drv_sel, .spare_thr, .erase_thr, .flash_read,
    .data_valid, .data_ready, .data_byte, .data_last, .cmd_done, .cyl_lo_out, .cyl_hi_out,
    .cmd_abort, .spare_value, .erase_value, .reads_attr, .crc_attr);
